// ### logic/mwsg_cfg.sv
// Memory wait and SDRAM geometry configuration block with its wait sequencer.
`timescale 1ns/1ps
`default_nettype none

module mwsg_cfg
	import mwsg_pkg::*;
(
	// Clock and power-on reset.
	input wire logic pclk,
	input wire logic presetn,
	// Manual reset pin, active low, asynchronous to pclk.
	input wire logic manual_reset_n,
	// APB slave port.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Memory access side.
	input wire logic access_start,
	input wire logic ext_wait_n,
	output logic access_busy,
	output logic access_done,
	// Decoded configuration for the memory controller.
	output logic ext_wait_ignored,
	output logic [MWSG_CNT_W-1:0] first_wait_cycles,
	output mwsg_geom_s area2_geometry
);

	// Current and next state of the whole block.
	mwsg_regs_s r_ff;
	mwsg_regs_s nxt_r;

	// Decoded values seen by the bus and the sequencer.
	logic [31:0] wait_word;
	logic [31:0] sdram_word;
	logic [31:0] status_word;
	logic wr_en;
	logic rd_setup;
	logic ext_wait_seen;
	logic manual_reset;
	logic [31:0] wr_merged; // Write data merged over the addressed register.
	logic [MWSG_CNT_W-1:0] start_count; // Count loaded when an access is taken.

	// Maps a four bit wait code onto its count of wait cycles.
	function automatic logic [MWSG_CNT_W-1:0] wait_cycles(input logic [3:0] code);
		logic [MWSG_CNT_W-1:0] n;
		n = 5'h00;
		case (code)
			4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: n = {1'b0, code};
			4'h7: n = 5'h08;
			4'h8: n = 5'h0A;
			4'h9: n = 5'h0C;
			4'hA: n = 5'h0E;
			4'hB: n = 5'h12;
			// Prohibited codes are treated as the longest wait, the safe side.
			default: n = 5'h18;
		endcase
		return n;
	endfunction : wait_cycles

	// Merges write data into a word, one byte lane per strobe bit.
	function automatic logic [31:0] merge_lanes(
		input logic [31:0] old_word,
		input logic [31:0] new_word,
		input logic [3:0] strobe
	);
		logic [31:0] w;
		w = old_word;
		for (int i = 0; i < 4; i++)
		begin
			if (strobe[i])
			begin
				w[i*8 +: 8] = new_word[i*8 +: 8];
			end
		end
		return w;
	endfunction : merge_lanes

	// Builds the read view of the wait register; all other bits stay zero.
	always_comb
	begin
		wait_word = 32'h00000000;
		wait_word[MWSG_WAIT_CODE_LSB +: 4] = r_ff.wait_code;
		wait_word[MWSG_WAIT_MASK_BIT] = r_ff.wait_mask;
	end

	// Builds the read view of the SDRAM register; bit 18 and others read zero.
	always_comb
	begin
		sdram_word = 32'h00000000;
		sdram_word[MWSG_ROW_LSB +: 2] = r_ff.row_code;
		sdram_word[MWSG_COL_LSB +: 2] = r_ff.col_code;
	end

	// Builds the read only status view of the sequencer.
	always_comb
	begin
		status_word = 32'h00000000;
		status_word[MWSG_STAT_BUSY_BIT] = (r_ff.state != MWSG_IDLE);
		status_word[MWSG_STAT_EXTW_BIT] = ext_wait_seen;
		status_word[MWSG_STAT_CNT_LSB +: MWSG_CNT_W] = r_ff.count;
	end

	// Bus decode: writes act in the access phase, reads are fetched in setup.
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;

	// External wait after the synchroniser, active high.
	assign ext_wait_seen = ~r_ff.extw_sync[1];

	// Manual reset after the synchroniser, active high.
	assign manual_reset = ~r_ff.mrst_sync[1];

	// Merges the write data into the addressed register, one byte lane per strobe bit.
	always_comb
	begin
		case (paddr)
			MWSG_OFS_SDRAM_CTRL: wr_merged = merge_lanes(sdram_word, pwdata, pstrb);
			default: wr_merged = merge_lanes(wait_word, pwdata, pstrb);
		endcase
	end

	// Picks the count for a new access; an honoured pin must pass the synchroniser first.
	always_comb
	begin
		start_count = wait_cycles(r_ff.wait_code);
		// Without this floor a short access would end before the pin could be seen.
		if (!r_ff.wait_mask && (start_count < MWSG_SYNC_WAIT))
		begin
			start_count = MWSG_SYNC_WAIT;
		end
	end

	// Computes the next state of the registers, the bus and the sequencer.
	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.done = 1'b0;

		// Both pins pass two flip-flops before anything reads them.
		nxt_r.extw_sync = {r_ff.extw_sync[0], ext_wait_n};
		nxt_r.mrst_sync = {r_ff.mrst_sync[0], manual_reset_n};

		// Read data is captured in the setup cycle and held through access.
		if (rd_setup)
		begin
			nxt_r.slverr = 1'b0;
			case (paddr)
				MWSG_OFS_WAIT_CTRL: nxt_r.rdata = wait_word;
				MWSG_OFS_SDRAM_CTRL: nxt_r.rdata = sdram_word;
				MWSG_OFS_STATUS: nxt_r.rdata = status_word;
				default:
				begin
					// Unmapped addresses read zero and flag an error.
					nxt_r.rdata = 32'h00000000;
					nxt_r.slverr = 1'b1;
				end
			endcase
			// Writes never carry read data back.
			if (pwrite)
			begin
				nxt_r.rdata = 32'h00000000;
			end
		end

		// Register writes take effect at the end of the access phase.
		if (wr_en)
		begin
			case (paddr)
				MWSG_OFS_WAIT_CTRL:
				begin
					// Only the stored fields are kept, reserved bits are dropped.
					nxt_r.wait_code = wr_merged[MWSG_WAIT_CODE_LSB +: 4];
					nxt_r.wait_mask = wr_merged[MWSG_WAIT_MASK_BIT];
				end
				MWSG_OFS_SDRAM_CTRL:
				begin
					// Bit 18 is not stored, so it can never read back as one.
					nxt_r.row_code = wr_merged[MWSG_ROW_LSB +: 2];
					nxt_r.col_code = wr_merged[MWSG_COL_LSB +: 2];
				end
				default:
				begin
					// Status and unmapped offsets ignore writes.
					nxt_r.rdata = r_ff.rdata;
				end
			endcase
		end

		// Wait sequencer for the first access cycle.
		case (r_ff.state)
			MWSG_IDLE:
			begin
				if (access_start)
				begin
					nxt_r.count = start_count;
					// A zero count skips straight to the external wait check.
					if (start_count == 5'h00)
					begin
						nxt_r.state = MWSG_EXTEND;
					end
					else
					begin
						nxt_r.state = MWSG_COUNT;
					end
				end
			end
			MWSG_COUNT:
			begin
				// Programmed wait cycles run out before the pin is looked at.
				nxt_r.count = r_ff.count - 5'h01;
				if (r_ff.count == 5'h01)
				begin
					nxt_r.state = MWSG_EXTEND;
				end
			end
			MWSG_EXTEND:
			begin
				// The pin stretches the access unless the mask ignores it.
				if (r_ff.wait_mask || !ext_wait_seen)
				begin
					nxt_r.state = MWSG_IDLE;
					nxt_r.done = 1'b1;
				end
			end
			default:
			begin
				nxt_r.state = MWSG_IDLE;
			end
		endcase

		// Manual reset restores the wait register and the sequencer only.
		if (manual_reset)
		begin
			nxt_r.wait_code = MWSG_WAIT_CODE_RST;
			nxt_r.wait_mask = MWSG_WAIT_MASK_RST;
			nxt_r.state = MWSG_IDLE;
			nxt_r.count = 5'h00;
			nxt_r.done = 1'b0;
			// The SDRAM fields are deliberately left as they are.
			nxt_r.row_code = r_ff.row_code;
			nxt_r.col_code = r_ff.col_code;
		end
	end

	// Registers the whole state; power-on reset loads every field with its reset value.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r_ff.wait_code <= MWSG_WAIT_CODE_RST;
			r_ff.wait_mask <= MWSG_WAIT_MASK_RST;
			r_ff.row_code <= MWSG_ROW_RST;
			r_ff.col_code <= MWSG_COL_RST;
			r_ff.extw_sync <= 2'h3;
			r_ff.mrst_sync <= 2'h3;
			r_ff.state <= MWSG_IDLE;
			r_ff.count <= 5'h00;
			r_ff.done <= 1'b0;
			r_ff.rdata <= 32'h00000000;
			r_ff.slverr <= 1'b0;
		end
		else
		begin
			r_ff <= nxt_r;
		end
	end

	// The slave answers in the first access cycle.
	assign pready = psel & penable;
	assign prdata = r_ff.rdata;
	assign pslverr = psel & penable & r_ff.slverr;

	// Sequencer outputs towards the memory controller.
	assign access_busy = (r_ff.state != MWSG_IDLE);
	assign access_done = r_ff.done;

	// Configuration outputs come straight from the stored fields.
	assign ext_wait_ignored = r_ff.wait_mask;
	assign first_wait_cycles = wait_cycles(r_ff.wait_code);

	// Decodes the area 2 geometry; a prohibited code is shown as the widest.
	always_comb
	begin
		case (r_ff.row_code)
			2'h0: area2_geometry.row_bits = 4'hB;
			2'h1: area2_geometry.row_bits = 4'hC;
			default: area2_geometry.row_bits = 4'hD;
		endcase
		case (r_ff.col_code)
			2'h0: area2_geometry.col_bits = 4'h8;
			2'h1: area2_geometry.col_bits = 4'h9;
			default: area2_geometry.col_bits = 4'hA;
		endcase
	end

endmodule : mwsg_cfg

`default_nettype wire

// ### logic/mwsg_pkg.sv
// Package with register map, field layout and reset values of the memory wait block.
package mwsg_pkg;

	// Byte offsets of the registers on the APB bus.
	localparam logic [7:0] MWSG_OFS_WAIT_CTRL = 8'h00;
	localparam logic [7:0] MWSG_OFS_SDRAM_CTRL = 8'h04;
	localparam logic [7:0] MWSG_OFS_STATUS = 8'h08;

	// Field positions in the area 0 access wait control register.
	localparam int MWSG_WAIT_CODE_LSB = 7;
	localparam int MWSG_WAIT_MASK_BIT = 6;

	// Field positions in the SDRAM control register.
	localparam int MWSG_ROW_LSB = 19;
	localparam int MWSG_COL_LSB = 16;

	// Reset values of the stored fields.
	localparam logic [3:0] MWSG_WAIT_CODE_RST = 4'hA;
	localparam logic MWSG_WAIT_MASK_RST = 1'b0;
	localparam logic [1:0] MWSG_ROW_RST = 2'h0;
	localparam logic [1:0] MWSG_COL_RST = 2'h0;

	// Field positions in the status register.
	localparam int MWSG_STAT_BUSY_BIT = 0;
	localparam int MWSG_STAT_EXTW_BIT = 1;
	localparam int MWSG_STAT_CNT_LSB = 8;

	// Width of the wait cycle counter; the longest wait is 24 cycles.
	localparam int MWSG_CNT_W = 5;

	// Shortest first access while the wait pin is honoured; covers both synchroniser stages.
	localparam logic [MWSG_CNT_W-1:0] MWSG_SYNC_WAIT = 5'h02;

	// States of the first access wait sequencer.
	typedef enum logic [1:0]
	{
		MWSG_IDLE,
		MWSG_COUNT,
		MWSG_EXTEND
	} mwsg_state_e;

	// Decoded SDRAM address geometry for area 2.
	typedef struct packed
	{
		logic [3:0] row_bits;
		logic [3:0] col_bits;
	} mwsg_geom_s;

	// Whole state of the block, registered in one place.
	typedef struct packed
	{
		logic [3:0] wait_code;
		logic wait_mask;
		logic [1:0] row_code;
		logic [1:0] col_code;
		logic [1:0] extw_sync;
		logic [1:0] mrst_sync;
		mwsg_state_e state;
		logic [MWSG_CNT_W-1:0] count;
		logic done;
		logic [31:0] rdata;
		logic slverr;
	} mwsg_regs_s;

endpackage : mwsg_pkg

// ### logic/unused_placeholder_none.sv
// Intentionally holds no logic; the design is entirely in mwsg_cfg.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### sim/mwsg_mem_model.sv
// Model of the external memory that stretches accesses with its wait pin.
`timescale 1ns/1ps
`default_nettype none
module mwsg_mem_model
(
	// Clock, reset and access status.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic access_busy,
	// Cycles the memory holds off each access.
	input wire logic [4:0] hold_len,
	// Wait pin, active low, pulled up when released.
	output logic ext_wait_n
);
	// Cycles the current access has been held.
	logic [4:0] held_ff;
	// Count busy cycles so the pin is held from the start of each access.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			held_ff <= 5'h00;
		else
			held_ff <= access_busy ? held_ff + 5'h01 : 5'h00;
	// The pull-up wins whenever the memory lets go of the pin.
	assign ext_wait_n = !(access_busy && held_ff < hold_len);
endmodule : mwsg_mem_model
`default_nettype wire

// ### sim/mwsg_cfg_props.sv
// Checker for the memory wait configuration block.
`timescale 1ns/1ps
`default_nettype none
module mwsg_cfg_props
	import mwsg_pkg::*;
(
	// Watched ports.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic manual_reset_n,
	input wire logic psel,
	input wire logic access_start,
	input wire logic ext_wait_n,
	input wire logic access_busy,
	input wire logic access_done,
	input wire logic ext_wait_ignored,
	input wire logic [MWSG_CNT_W-1:0] first_wait_cycles,
	input wire mwsg_geom_s area2_geometry
);
	// Cycles since the last accepted start.
	logic [5:0] run_ff;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			run_ff <= 6'h00;
		else
			run_ff <= (access_start && !access_busy) ? 6'h01 : run_ff + 6'h01;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_reset_vals: assert property ($rose(presetn) |-> first_wait_cycles == 5'h0E
		&& !ext_wait_ignored) else $error("reset values wrong");
	a_wait_legal: assert property (first_wait_cycles inside {[5'h00:5'h06],
		5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h12, 5'h18}) else $error("wait count illegal");
	a_row_legal: assert property (area2_geometry.row_bits inside {4'hB, 4'hC, 4'hD})
		else $error("row width illegal");
	a_col_legal: assert property (area2_geometry.col_bits inside {4'h8, 4'h9, 4'hA})
		else $error("column width illegal");
	a_wait_len: assert property (access_done && ext_wait_ignored |-> run_ff ==
		({1'b0, first_wait_cycles} + 6'h02))
		else $error("wait length wrong");
	a_mask_ignore: assert property (access_start && !access_busy && ext_wait_ignored
		|-> ##[2:26] access_done) else $error("masked wait not ignored");
	a_ext_hold: assert property ((access_busy && !ext_wait_ignored && !ext_wait_n) [*4]
		|=> !access_done) else $error("access ended during external wait");
	a_manual_keep: assert property (!manual_reset_n && !psel |=> $stable(area2_geometry))
		else $error("manual reset changed geometry");
	c_done: cover property (access_done && ext_wait_ignored);
	c_held: cover property ((access_busy && !ext_wait_n) [*4]);
	c_manual: cover property (!manual_reset_n);
endmodule : mwsg_cfg_props
bind mwsg_cfg mwsg_cfg_props i_mwsg_cfg_props (.pclk(pclk), .presetn(presetn),
	.manual_reset_n(manual_reset_n), .psel(psel), .access_start(access_start),
	.ext_wait_n(ext_wait_n), .access_busy(access_busy), .access_done(access_done),
	.ext_wait_ignored(ext_wait_ignored), .first_wait_cycles(first_wait_cycles),
	.area2_geometry(area2_geometry));
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the memory wait configuration block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import mwsg_pkg::*;
;
	// Stimulus starts idle at time zero.
	logic pclk = 1'b0, presetn = 1'b0, manual_reset_n = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, access_start = 1'b0, pready, pslverr, access_busy, access_done;
	logic ext_wait_n, ext_wait_ignored, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, pw;
	logic [4:0] first_wait_cycles, e, hold_len = 5'h00;
	mwsg_geom_s area2_geometry;
	int mismatches = 0, cmp_count = 0, cyc = 0, seed = 65021, n;
	always #50 pclk = ~pclk;
	mwsg_cfg i_mwsg_cfg (.pclk(pclk), .presetn(presetn), .manual_reset_n(manual_reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.access_start(access_start), .ext_wait_n(ext_wait_n), .access_busy(access_busy),
		.access_done(access_done), .ext_wait_ignored(ext_wait_ignored),
		.first_wait_cycles(first_wait_cycles), .area2_geometry(area2_geometry));
	mwsg_mem_model i_mwsg_mem_model (.pclk(pclk), .presetn(presetn),
		.access_busy(access_busy), .hold_len(hold_len), .ext_wait_n(ext_wait_n));
	// Expected first access wait for a code.
	function automatic logic [4:0] wait_of(input logic [3:0] c);
		logic [4:0] t [13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08,
			5'h0A, 5'h0C, 5'h0E, 5'h12, 5'h18};
		return t[c];
	endfunction : wait_of
	// One APB transfer; read data and error are taken when pready is seen.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// One access; c counts cycles from the take to the done pulse.
	task automatic acc(output int c);
		@(posedge pclk);
		access_start <= 1'b1;
		@(posedge pclk);
		access_start <= 1'b0;
		c = 0;
		do
		begin
			@(negedge pclk);
			c++;
			if (c == 1)
			begin
				chk(32'(access_busy), 32'h1);
			end
		end
		while (access_done !== 1'b1);
		chk(32'(access_busy), 32'h0);
	endtask : acc
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	// Cut a hang short.
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc > 5000)
		begin
			mismatches++;
			stop_test();
		end
	end
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, MWSG_OFS_WAIT_CTRL, 32'h0);
		chk(rd, 32'h500);
		chk(32'(area2_geometry), 32'hB8);
		// Every legal wait code, alternating the mask, code zero both ways.
		for (int k = 0; k < 14; k++)
		begin
			hold_len <= (k == 0) ? 5'h08 : 5'({$random(seed)} % 20);
			pw = {21'h0, 4'(k % 13), k[0], 6'h00};
			apb(1'b1, MWSG_OFS_WAIT_CTRL, pw);
			apb(1'b0, MWSG_OFS_WAIT_CTRL, 32'h0);
			chk(rd, pw);
			chk(32'(ext_wait_ignored), 32'(k[0]));
			e = wait_of(4'(k % 13));
			chk(32'(first_wait_cycles), 32'(e));
			// Falling edges from the take through the done pulse.
			e = e + 5'h02;
			acc(n);
			chk(32'(k[0] ? n == e : n > hold_len && n >= e), 32'h1);
		end
		// Row and column widths, widest pair first.
		for (int j = 0; j < 7; j++)
		begin
			n = (j == 0) ? 8 : {$random(seed)} % 9;
			pw = {11'h0, 2'(n % 3), 1'b0, 2'(n / 3), 16'h0};
			apb(1'b1, MWSG_OFS_SDRAM_CTRL, pw);
			apb(1'b0, MWSG_OFS_SDRAM_CTRL, 32'h0);
			chk(rd, pw);
			chk(32'(area2_geometry), 32'({4'(11 + n % 3), 4'(8 + n / 3)}));
		end
		@(posedge pclk);
		manual_reset_n <= 1'b0;
		repeat (4) @(posedge pclk);
		manual_reset_n <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, MWSG_OFS_SDRAM_CTRL, 32'h0);
		chk(rd, pw);
		chk(32'(first_wait_cycles), 32'hE);
		// An idle sequencer shows an all-zero status word without an error.
		apb(1'b0, MWSG_OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		chk(32'(err), 32'h0);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, MWSG_OFS_SDRAM_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		chk(32'(err), 32'h1);
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
